// ==== rtl/buck4_pkg.sv ====
// Purpose: shared constants and types for the fourth buck converter control registers
// Assumes: 40 MHz ref_clk, AXI4-Lite register access, 32-bit data
// Notes: printed register offsets are indices; byte address is four times the index
package buck4_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;

  // register indices; byte address is index times four
  localparam logic [15:0] IDX_CTRL_ONE = 16'h4064;
  localparam logic [15:0] IDX_CTRL_TWO = 16'h4065;
  localparam logic [15:0] IDX_KEY = 16'h4070;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h4071;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h4072;
  localparam logic [15:0] IDX_STATUS = 16'h4073;

  // field positions
  localparam int FOLLOWER_BIT = 13;
  localparam int PHASE_BIT = 12;
  localparam int FLOAT_BIT = 7;
  localparam int SS_LSB = 4;
  localparam int LIM_LSB = 2;
  localparam int CAP_LSB = 0;
  localparam int UVACT_LSB = 14;
  localparam int HWSRC_LSB = 11;
  localparam int HWVSEL_BIT = 10;
  localparam int UV_IRQ_BIT = 0;

  // values after reset
  localparam logic [1:0] SS_RST = 2'h1;
  localparam logic [1:0] LIM_RST = 2'h1;
  localparam logic [1:0] CAP_RST = 2'h0;
  localparam logic [1:0] UVACT_RST = 2'h0;
  localparam logic [1:0] HWSRC_RST = 2'h0;

  // arbitrary unlock value for the security key
  localparam logic [15:0] KEY_UNLOCK = 16'hA5C3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // soft-start step durations
  localparam int CLK_PERIOD_NS = 25;
  localparam int SS_STEP1_NS = 512000;
  localparam int SS_STEP2_NS = 4096000;
  localparam int SS_STEP3_NS = 32768000;
  localparam int SS_STEP1_CYC = SS_STEP1_NS / CLK_PERIOD_NS;
  localparam int SS_STEP2_CYC = SS_STEP2_NS / CLK_PERIOD_NS;
  localparam int SS_STEP3_CYC = SS_STEP3_NS / CLK_PERIOD_NS;
  localparam int SS_CNT_W = 21;
  localparam logic [1:0] SS_LEVEL_FULL = 2'h3;
  localparam logic [1:0] SS_LEVEL_LAST = 2'h2;

  typedef enum logic [1:0] {
    UV_IGNORE = 2'b00,
    UV_SHUTDOWN = 2'b01,
    UV_RESET = 2'b10,
    UV_RESERVED = 2'b11
  } uv_action_t;

  typedef enum logic [1:0] {
    HWC_OFF = 2'b00,
    HWC_IN1 = 2'b01,
    HWC_IN2 = 2'b10,
    HWC_EITHER = 2'b11
  } hwc_source_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_CTRL_ONE = 3'b001,
    SEL_CTRL_TWO = 3'b010,
    SEL_KEY = 3'b011,
    SEL_IRQ_STATUS = 3'b100,
    SEL_IRQ_MASK = 3'b101,
    SEL_STATUS = 3'b110
  } reg_sel_t;

  typedef enum logic [1:0] {
    SS_IDLE = 2'b00,
    SS_RAMP = 2'b01,
    SS_FULL = 2'b10
  } ss_state_t;
endpackage

// ==== rtl/softstart_if.sv ====
`timescale 1ns/10ps
// Purpose: link between register block and soft-start sequencer
// Assumes: both ends on ref_clk
// Notes: level 3 means full current limit
interface softstart_if;
  logic start;
  logic abort;
  logic [1:0] step_select;
  logic [1:0] level;
  logic busy;

  modport ctrl (output start, output abort, output step_select, input level, input busy);
  modport timer (input start, input abort, input step_select, output level, output busy);
endinterface

// ==== rtl/softstart_timer.sv ====
`timescale 1ns/10ps
// Purpose: steps the start-up current limit through three intermediate levels
// Assumes: start is a one-cycle pulse and abort a level held while stopped, both on ref_clk
// Notes: step length sampled at every step boundary
module softstart_timer
  import buck4_pkg::*;
#(
  parameter int CYC1 = SS_STEP1_CYC,
  parameter int CYC2 = SS_STEP2_CYC,
  parameter int CYC3 = SS_STEP3_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // control side
  softstart_if.timer ss
);
  ss_state_t state, next_state;
  logic [SS_CNT_W-1:0] cnt, next_cnt;
  logic [1:0] level, next_level;

  function automatic logic [SS_CNT_W-1:0] step_cycles(input logic [1:0] sel);
    case (sel)
      2'h1: step_cycles = SS_CNT_W'(CYC1 - 1);
      2'h2: step_cycles = SS_CNT_W'(CYC2 - 1);
      default: step_cycles = SS_CNT_W'(CYC3 - 1);
    endcase
  endfunction

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_level = level;
    case (state)
      SS_IDLE: begin
        if (ss.start) begin
          if (ss.step_select == 2'h0) begin
            next_state = SS_FULL;
            next_level = SS_LEVEL_FULL;
          end else begin
            next_state = SS_RAMP;
            next_level = 2'h0;
            next_cnt = step_cycles(ss.step_select);
          end
        end
      end
      SS_RAMP: begin
        if (cnt == '0) begin
          if (level == SS_LEVEL_LAST) begin
            next_state = SS_FULL;
            next_level = SS_LEVEL_FULL;
          end else begin
            next_level = level + 2'h1;
            next_cnt = step_cycles(ss.step_select);
          end
        end else begin
          next_cnt = cnt - SS_CNT_W'(1);
        end
      end
      SS_FULL: begin
        next_state = SS_FULL;
      end
      default: begin
        next_state = SS_IDLE;
      end
    endcase
    // disable ends any ramp at once
    if (ss.abort) begin
      next_state = SS_IDLE;
      next_level = 2'h0;
      next_cnt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= SS_IDLE;
      cnt <= '0;
      level <= 2'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      level <= next_level;
    end
  end

  assign ss.level = level;
  assign ss.busy = (state == SS_RAMP);
endmodule

// ==== rtl/buck4_control_regs.sv ====
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
// Purpose: control registers of the fourth buck converter behind an AXI4-Lite slave
// Assumes: cfg_load and buck3 inputs come from logic on ref_clk; pins are asynchronous
// Notes: one write and one read in flight; unmapped addresses answer SLVERR
module buck4_control_regs
  import buck4_pkg::*;
#(
  parameter int SS_CYC1 = SS_STEP1_CYC,
  parameter int SS_CYC2 = SS_STEP2_CYC,
  parameter int SS_CYC3 = SS_STEP3_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // configuration load from OTP or ICE memory
  input wire logic cfg_load_strobe,
  input wire logic cfg_load_follower,
  input wire logic [1:0] cfg_load_cap,
  // converter three settings used in follower mode
  input wire logic buck3_phase_invert,
  input wire logic buck3_output_float,
  input wire logic [1:0] buck3_softstart,
  input wire logic [1:0] buck3_current_limit,
  // asynchronous pins
  input wire logic buck4_enable_pin,
  input wire logic uv_pin,
  input wire logic hwc1_pin,
  input wire logic hwc2_pin,
  // interrupt
  output logic irq,
  // converter controls
  output logic follower_mode_select,
  output logic switch_clock_phase_invert,
  output logic output_float_on_disable,
  output logic [1:0] hysteretic_current_limit,
  output logic [1:0] output_cap_range,
  output logic [1:0] softstart_level,
  output logic converter_shutdown,
  output logic device_reset_req,
  output logic hw_control_active,
  output logic hw_control_voltage_select
);
  localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = {IDX_CTRL_ONE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = {IDX_CTRL_TWO, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_KEY = {IDX_KEY, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    case (addr)
      ADDR_CTRL_ONE: decode = SEL_CTRL_ONE;
      ADDR_CTRL_TWO: decode = SEL_CTRL_TWO;
      ADDR_KEY: decode = SEL_KEY;
      ADDR_IRQ_STATUS: decode = SEL_IRQ_STATUS;
      ADDR_IRQ_MASK: decode = SEL_IRQ_MASK;
      ADDR_STATUS: decode = SEL_STATUS;
      default: decode = SEL_NONE;
    endcase
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wr,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? wr[15:8] : old[15:8], strb[0] ? wr[7:0] : old[7:0]};
  endfunction

  // pin synchronisers
  logic [3:0] pin_meta, pin_sync;
  logic uv_prev, en_prev;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      uv_prev <= 1'b0;
      en_prev <= 1'b0;
    end else begin
      pin_meta <= {hwc2_pin, hwc1_pin, uv_pin, buck4_enable_pin};
      pin_sync <= pin_meta;
      uv_prev <= pin_sync[1];
      en_prev <= pin_sync[0] & ~converter_shutdown;
    end
  end
  logic enable_sync, uv_rise, hwc1_sync, hwc2_sync, run_now;
  assign enable_sync = pin_sync[0];
  assign uv_rise = pin_sync[1] & ~uv_prev;
  assign hwc1_sync = pin_sync[2];
  assign hwc2_sync = pin_sync[3];
  assign run_now = enable_sync & ~converter_shutdown;

  // register state
  logic follower, phase, float_off, key_unlocked, shutdown, reset_req;
  logic [1:0] ss_sel, lim, cap, hw_src;
  logic [1:0] uv_act;
  logic hw_vsel;
  logic [15:0] irq_status, irq_mask;
  logic next_follower, next_phase, next_float_off, next_key_unlocked, next_shutdown;
  logic next_reset_req, next_hw_vsel;
  logic [1:0] next_ss_sel, next_lim, next_cap, next_hw_src, next_uv_act;
  logic [15:0] next_irq_status, next_irq_mask;

  // axi state
  logic aw_hold, w_hold, bvalid, rvalid, awready, wready, arready;
  logic [ADDR_W-1:0] aw_addr;
  logic [15:0] w_data;
  logic [1:0] w_strb, bresp, rresp;
  logic [DATA_W-1:0] rdata;
  logic next_aw_hold, next_w_hold, next_bvalid, next_rvalid;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [15:0] next_w_data;
  logic [1:0] next_w_strb, next_bresp, next_rresp;
  logic [DATA_W-1:0] next_rdata;

  logic [15:0] ctrl_one_img, ctrl_two_img, status_img;
  assign ctrl_one_img = {2'b00, follower, phase, 4'h0, float_off, 1'b0, ss_sel, lim, cap};
  assign ctrl_two_img = {uv_act, 1'b0, hw_src, hw_vsel, 10'h000};
  assign status_img = {10'h000, hw_control_active, softstart_level, converter_shutdown,
                       run_now, enable_sync};

  function automatic logic [15:0] read_img(input reg_sel_t sel, input logic [15:0] one,
                                           input logic [15:0] two, input logic key,
                                           input logic [15:0] ist, input logic [15:0] imk,
                                           input logic [15:0] sts);
    case (sel)
      SEL_CTRL_ONE: read_img = one;
      SEL_CTRL_TWO: read_img = two;
      SEL_KEY: read_img = {15'h0000, key};
      SEL_IRQ_STATUS: read_img = ist;
      SEL_IRQ_MASK: read_img = imk;
      SEL_STATUS: read_img = sts;
      default: read_img = 16'h0000;
    endcase
  endfunction

  logic do_write;
  reg_sel_t wsel;
  logic [15:0] wmerged;
  assign do_write = aw_hold & w_hold & ~bvalid;
  assign wsel = decode(aw_addr);
  assign wmerged = merge16(read_img(wsel, ctrl_one_img, ctrl_two_img, key_unlocked,
                                    irq_status, irq_mask, status_img), w_data, w_strb);

  always_comb begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold = w_hold;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_awvalid && awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata[15:0];
      next_w_strb = s_axi_wstrb[1:0];
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata = {16'h0000, read_img(decode(s_axi_araddr), ctrl_one_img, ctrl_two_img,
                                       key_unlocked, irq_status, irq_mask, status_img)};
      next_rresp = (decode(s_axi_araddr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
      w_hold <= 1'b0;
      w_data <= 16'h0000;
      w_strb <= 2'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
    end else begin
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold <= next_w_hold;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      awready <= ~next_aw_hold & ~next_bvalid;
      wready <= ~next_w_hold & ~next_bvalid;
      arready <= ~next_rvalid;
    end
  end

  // register file and undervoltage handling
  always_comb begin
    next_follower = follower;
    next_phase = phase;
    next_float_off = float_off;
    next_ss_sel = ss_sel;
    next_lim = lim;
    next_cap = cap;
    next_uv_act = uv_act;
    next_hw_src = hw_src;
    next_hw_vsel = hw_vsel;
    next_key_unlocked = key_unlocked;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    next_shutdown = shutdown;
    next_reset_req = 1'b0;
    if (do_write) begin
      case (wsel)
        SEL_CTRL_ONE: begin
          next_phase = wmerged[PHASE_BIT];
          next_float_off = wmerged[FLOAT_BIT];
          next_ss_sel = wmerged[SS_LSB +: 2];
          if (key_unlocked) begin
            next_lim = wmerged[LIM_LSB +: 2];
          end
        end
        SEL_CTRL_TWO: begin
          next_uv_act = wmerged[UVACT_LSB +: 2];
          next_hw_src = wmerged[HWSRC_LSB +: 2];
          next_hw_vsel = wmerged[HWVSEL_BIT];
        end
        // any other value relocks the key
        SEL_KEY: next_key_unlocked = (wmerged == KEY_UNLOCK);
        SEL_IRQ_STATUS: next_irq_status = irq_status & ~wmerged;
        SEL_IRQ_MASK: next_irq_mask = wmerged;
        default: next_key_unlocked = key_unlocked;
      endcase
    end
    // only the load path reaches these two fields
    if (cfg_load_strobe) begin
      next_follower = cfg_load_follower;
      next_cap = cfg_load_cap;
    end
    // a disable clears a latched shutdown so the next enable restarts
    if (!enable_sync) begin
      next_shutdown = 1'b0;
    end
    if (uv_rise) begin
      // set after the clear so an event in the clearing cycle survives
      next_irq_status[UV_IRQ_BIT] = 1'b1;
      case (uv_act)
        UV_SHUTDOWN: next_shutdown = 1'b1;
        UV_RESET: next_reset_req = 1'b1;
        default: next_shutdown = next_shutdown;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      follower <= 1'b0;
      phase <= 1'b0;
      float_off <= 1'b0;
      ss_sel <= SS_RST;
      lim <= LIM_RST;
      cap <= CAP_RST;
      uv_act <= UVACT_RST;
      hw_src <= HWSRC_RST;
      hw_vsel <= 1'b0;
      key_unlocked <= 1'b0;
      irq_mask <= 16'h0000;
      irq_status <= 16'h0000;
      shutdown <= 1'b0;
      reset_req <= 1'b0;
    end else begin
      follower <= next_follower;
      phase <= next_phase;
      float_off <= next_float_off;
      ss_sel <= next_ss_sel;
      lim <= next_lim;
      cap <= next_cap;
      uv_act <= next_uv_act;
      hw_src <= next_hw_src;
      hw_vsel <= next_hw_vsel;
      key_unlocked <= next_key_unlocked;
      irq_mask <= next_irq_mask;
      irq_status <= next_irq_status;
      shutdown <= next_shutdown;
      reset_req <= next_reset_req;
    end
  end

  // soft-start sequencer
  softstart_if ss ();
  assign ss.start = run_now & ~en_prev;
  assign ss.abort = ~run_now;
  assign ss.step_select = follower ? buck3_softstart : ss_sel;

  softstart_timer #(
    .CYC1(SS_CYC1),
    .CYC2(SS_CYC2),
    .CYC3(SS_CYC3)
  ) u_softstart (
    .ref_clk(ref_clk),
    .srst(srst),
    .ss(ss.timer)
  );

  // hardware control input selection
  logic hwc_now;
  always_comb begin
    case (hw_src)
      HWC_IN1: hwc_now = hwc1_sync;
      HWC_IN2: hwc_now = hwc2_sync;
      HWC_EITHER: hwc_now = hwc1_sync | hwc2_sync;
      default: hwc_now = 1'b0;
    endcase
  end

  // registered outputs; masked bit 1 hides its status bit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq <= 1'b0;
      follower_mode_select <= 1'b0;
      switch_clock_phase_invert <= 1'b0;
      output_float_on_disable <= 1'b0;
      hysteretic_current_limit <= LIM_RST;
      output_cap_range <= CAP_RST;
      converter_shutdown <= 1'b0;
      device_reset_req <= 1'b0;
      hw_control_active <= 1'b0;
      hw_control_voltage_select <= 1'b0;
      softstart_level <= 2'h0;
    end else begin
      irq <= |(next_irq_status & ~next_irq_mask);
      follower_mode_select <= next_follower;
      switch_clock_phase_invert <= next_follower ? buck3_phase_invert : next_phase;
      output_float_on_disable <= next_follower ? buck3_output_float : next_float_off;
      hysteretic_current_limit <= next_follower ? buck3_current_limit : next_lim;
      output_cap_range <= next_cap;
      converter_shutdown <= next_shutdown;
      device_reset_req <= next_reset_req;
      hw_control_active <= hwc_now;
      hw_control_voltage_select <= hwc_now & hw_vsel;
      softstart_level <= ss.level;
    end
  end

  assign s_axi_awready = awready;
  assign s_axi_wready = wready;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = arready;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
endmodule

// ==== bench/buck4_assertions.sv ====
// Purpose: port-level property checks for the buck4 control registers
// Assumes: one clock domain; undervoltage bit unmasked when the pin rises
// Notes: bound into every buck4_control_regs instance
`timescale 1ns/10ps
module buck4_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // watched inputs
  input wire logic cfg_load_strobe,
  input wire logic cfg_load_follower,
  input wire logic [1:0] cfg_load_cap,
  input wire logic buck3_phase_invert,
  input wire logic [1:0] buck3_current_limit,
  input wire logic buck4_enable_pin,
  input wire logic uv_pin,
  // watched outputs
  input wire logic follower_mode_select,
  input wire logic [1:0] output_cap_range,
  input wire logic switch_clock_phase_invert,
  input wire logic [1:0] hysteretic_current_limit,
  input wire logic [1:0] softstart_level,
  input wire logic converter_shutdown,
  input wire logic device_reset_req,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // pin must stay up long enough to clear the synchroniser
  sequence s_uv_rise;
    $rose(uv_pin) ##1 uv_pin [*2];
  endsequence
  sequence s_irq_soon;
    ##[1:6] irq;
  endsequence
  property p_cfg_load;
    cfg_load_strobe |=> follower_mode_select == $past(cfg_load_follower)
      && output_cap_range == $past(cfg_load_cap);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("load not captured");
  property p_ro_hold;
    !cfg_load_strobe |=> $stable(follower_mode_select) && $stable(output_cap_range);
  endproperty
  a_ro_hold: assert property (p_ro_hold) else $error("load-only field moved");
  property p_follower;
    (follower_mode_select && $stable(buck3_phase_invert)
      && $stable(buck3_current_limit)) [*3] |-> switch_clock_phase_invert ==
      buck3_phase_invert && hysteretic_current_limit == buck3_current_limit;
  endproperty
  a_follower: assert property (p_follower) else $error("follower not tracking");
  property p_uv_irq;
    s_uv_rise |-> s_irq_soon;
  endproperty
  a_uv_irq: assert property (p_uv_irq) else $error("no irq on undervoltage");
  property p_rst_pulse;
    device_reset_req |=> !device_reset_req;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long");
  property p_act_irq;
    device_reset_req || $rose(converter_shutdown) |-> irq;
  endproperty
  a_act_irq: assert property (p_act_irq) else $error("action without irq");
  property p_shut_hold;
    converter_shutdown && buck4_enable_pin |=> converter_shutdown;
  endproperty
  a_shut_hold: assert property (p_shut_hold) else $error("shutdown dropped");
  property p_ss_mono;
    softstart_level != 2'h0 && buck4_enable_pin && !converter_shutdown |=>
      softstart_level >= $past(softstart_level) || converter_shutdown;
  endproperty
  a_ss_mono: assert property (p_ss_mono) else $error("soft-start stepped back");
endmodule

bind buck4_control_regs buck4_checker u_buck4_checker (.*);

// ==== bench/buck4_control_regs_tb.sv ====
// Purpose: self-checking bench for the buck4 control registers
// Assumes: soft-start steps shortened to 4, 8 and 16 cycles
// Notes: registers reached only through the axi4-lite tasks and the load task
`timescale 1ns/10ps
module buck4_control_regs_tb
  import buck4_pkg::*;
;
  localparam logic [17:0] A1 = {IDX_CTRL_ONE, 2'h0};
  localparam logic [17:0] A2 = {IDX_CTRL_TWO, 2'h0};
  localparam logic [17:0] AK = {IDX_KEY, 2'h0};
  localparam logic [17:0] AS = {IDX_IRQ_STATUS, 2'h0};
  localparam logic [17:0] AM = {IDX_IRQ_MASK, 2'h0};
  logic ref_clk = 1'b0, srst = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, hysteretic_current_limit, output_cap_range;
  logic cfg_load_strobe = 1'b0, cfg_load_follower = 1'b0, buck3_phase_invert = 1'b0;
  logic [1:0] cfg_load_cap = 2'h0, buck3_current_limit = 2'h0, buck3_softstart = 2'h0;
  logic buck3_output_float = 1'b0, buck4_enable_pin = 1'b0, uv_pin = 1'b0;
  logic hwc1_pin = 1'b0, hwc2_pin = 1'b0;
  logic irq, follower_mode_select, switch_clock_phase_invert, output_float_on_disable;
  logic [1:0] softstart_level;
  logic converter_shutdown, device_reset_req, hw_control_active, hw_control_voltage_select;
  logic [31:0] q;
  logic [1:0] r;
  logic sd, rq, e;
  int err_count = 0, tests_run = 0, cyc = 0, n;
  int st[4] = '{0, 4, 8, 16};

  buck4_control_regs #(.SS_CYC1(4), .SS_CYC2(8), .SS_CYC3(16)) u_buck4_control_regs (.*);

  always #12.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic wrap_up();
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [17:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [17:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    q = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic load(input logic f, input logic [1:0] c);
    @(posedge ref_clk);
    cfg_load_follower <= f;
    cfg_load_cap <= c;
    cfg_load_strobe <= 1'b1;
    @(posedge ref_clk);
    cfg_load_strobe <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic uv_pulse();
    uv_pin <= 1'b1;
    sd = 1'b0;
    rq = 1'b0;
    repeat (8) begin
      @(posedge ref_clk);
      sd |= converter_shutdown;
      rq |= device_reset_req;
    end
    uv_pin <= 1'b0;
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    rd(A1);
    chk("ctrl1 reset", q, 32'h0014);
    rd(A2);
    chk("ctrl2 reset", q, 32'h0);
    wr(A1, 16'hFFFF);
    rd(A1);
    chk("ctrl1 locked", q, 32'h10B4);
    chk("phase", switch_clock_phase_invert, 1'b1);
    chk("float", output_float_on_disable, 1'b1);
    wr(AK, KEY_UNLOCK);
    for (int i = 0; i < 4; i++) begin
      wr(A1, 16'(i * 4));
      rd(A1);
      chk("ctrl1 limit", q, i * 4);
      chk("limit out", hysteretic_current_limit, i);
    end
    wr(18'h00100, 16'h1);
    chk("bad wr", r, RESP_SLVERR);
    rd(18'h00100);
    chk("bad rd", {r, q[29:0]}, {RESP_SLVERR, 30'h0});
    wr(A1, 16'h1000);
    buck3_current_limit <= 2'h3;
    buck3_output_float <= 1'b1;
    load(1'b1, 2'h3);
    chk("follower", follower_mode_select, 1'b1);
    chk("cap", output_cap_range, 2'h3);
    chk("fol phase", switch_clock_phase_invert, 1'b0);
    chk("fol limit", hysteretic_current_limit, 2'h3);
    chk("fol float", output_float_on_disable, 1'b1);
    wr(A1, 16'h0);
    rd(A1);
    chk("ctrl1 ro", q, 32'h2003);
    load(1'b0, 2'h0);
    chk("cap clr", output_cap_range, 2'h0);
    for (int c = 0; c < 4; c++) begin
      wr(A1, 16'(c << 4));
      buck4_enable_pin <= 1'b1;
      n = 0;
      while (softstart_level !== 2'h3 && n < 200) begin
        @(posedge ref_clk);
        n++;
      end
      chk("ss time", n >= 3 * st[c] && n <= 3 * st[c] + 8, 1);
      buck4_enable_pin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk("ss off", softstart_level, 2'h0);
    end
    buck4_enable_pin <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      wr(A2, 16'(a << 14));
      uv_pulse();
      chk("irq", irq, 1'b1);
      chk("shutdown", sd, a == 1);
      chk("reset req", rq, a == 2);
      rd(AS);
      chk("uv flag", q, 32'h1);
      wr(AS, 16'h1);
      buck4_enable_pin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk("irq clear", irq, 1'b0);
      buck4_enable_pin <= 1'b1;
    end
    uv_pulse();
    wr(AM, 16'h1);
    repeat (2) @(posedge ref_clk);
    chk("masked", irq, 1'b0);
    wr(AM, 16'h0);
    repeat (2) @(posedge ref_clk);
    chk("unmasked", irq, 1'b1);
    wr(AS, 16'h1);
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 4; p++) begin
        wr(A2, 16'((s << 11) | ((p & 1) << 10)));
        hwc1_pin <= p[0];
        hwc2_pin <= p[1];
        repeat (5) @(posedge ref_clk);
        e = (s[0] & p[0]) | (s[1] & p[1]);
        chk("hw active", hw_control_active, e);
        chk("hw vsel", hw_control_voltage_select, e & p[0]);
      end
    end
    wrap_up();
  end
endmodule
